// file: common/scss_params.svh
`ifndef SCSS_PARAMS_SVH
`define SCSS_PARAMS_SVH

`define SCSS_MCLK_MHZ        125
`define SCSS_ADDR_W          8
`define SCSS_OFS_SYSCFG      8'h00
`define SCSS_OFS_PLLCFG      8'h04
`define SCSS_OFS_PLLDIV      8'h08
`define SCSS_OFS_STATUS      8'h0c

`define SCSS_SEL_WAKEUP      2'h0
`define SCSS_SEL_UNDEF       2'h1
`define SCSS_SEL_PLLPRE      2'h2
`define SCSS_SEL_DIRECT      2'h3

`define SCSS_SEL_LSB         0
`define SCSS_BYP_BIT         0
`define SCSS_BAND_LSB        1
`define SCSS_REFSEL_BIT      3
`define SCSS_K1_LSB          16
`define SCSS_P_LSB           0
`define SCSS_N_LSB           8
`define SCSS_K2_LSB          16
`define SCSS_ST_SRC_LSB      0
`define SCSS_ST_PARK_BIT     2
`define SCSS_ST_LOCK_BIT     3
`define SCSS_ST_CLK_BIT      4

`define SCSS_RST_SEL         2'h0
`define SCSS_RST_BYP         1'h1

`define SCSS_B0_MIN_MHZ      50
`define SCSS_B0_MAX_MHZ      110
`define SCSS_B1_MIN_MHZ      100
`define SCSS_B1_MAX_MHZ      200
`define SCSS_DPLL_STEP       16'h0040

`endif

// file: common/scss_pkg.sv
package scss_pkg;
`include "scss_params.svh"

    typedef enum logic [1:0] {SRC_WAKE, SRC_PLL, SRC_PRE, SRC_DIRECT} scss_src_e;
    typedef enum logic {SW_RUN, SW_PARK} scss_sw_e;

    typedef struct packed {
        logic [1:0] sel;
        logic       bypass;
        logic [1:0] band;
        logic       refsel;
        logic [9:0] prescaler_divide_field;
        logic [3:0] pll_input_divide_field;
        logic [6:0] pll_feedback_multiply_field;
        logic [6:0] pll_output_divide_field;
    } scss_cfg_s;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] lvl;
        logic [3:0] rise;
    } scss_sync_st_s;

    typedef struct packed {
        logic [3:0]  pcnt;
        logic [7:0]  vcnt;
        logic [15:0] acc;
        logic [15:0] inc;
        logic [6:0]  k2cnt;
        logic        sys_lvl;
        logic        locked;
    } scss_dpll_st_s;

    typedef struct packed {
        scss_cfg_s   cfg;
        logic [31:0] rdata;
        scss_src_e   cur;
        scss_sw_e    sw;
        logic [9:0]  k1cnt;
        logic        pre_lvl;
        logic        sys_clk;
        logic        sys_rise;
        logic        locked;
    } scss_top_st_s;

    // high phase length of a divide-by-(div+1) counter
    function automatic logic [10:0] scss_high_len(input logic [9:0] div);
        logic [10:0] s;
        s = {1'b0, div} + 11'h002;
        return s >> 1;
    endfunction : scss_high_len

    // phase increment per mclk for a vco rate, saturated at one per cycle
    function automatic logic [15:0] scss_inc_of(input int mhz);
        int v;
        v = (mhz * 65536) / `SCSS_MCLK_MHZ;
        if (v > 65535) v = 65535;
        return v[15:0];
    endfunction : scss_inc_of

    function automatic logic [15:0] scss_band_min(input logic [1:0] band);
        return (band == 2'h0) ? scss_inc_of(`SCSS_B0_MIN_MHZ)
                              : scss_inc_of(`SCSS_B1_MIN_MHZ);
    endfunction : scss_band_min

    function automatic logic [15:0] scss_band_max(input logic [1:0] band);
        return (band == 2'h0) ? scss_inc_of(`SCSS_B0_MAX_MHZ)
                              : scss_inc_of(`SCSS_B1_MAX_MHZ);
    endfunction : scss_band_max

endpackage : scss_pkg

// file: dv/scss_top_assertions.sv
`timescale 1ns/100ps
module scss_top_chk (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        sys_clk_out,
    input wire logic        sys_clk_rise,
    input wire logic [1:0]  active_source,
    input wire logic        pll_locked
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic sel_wr;
    assign sel_wr = reg_wr && reg_addr == 8'h00;

    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    chk_rdata_unmapped: assert property (
        reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr > 8'h0c)
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    chk_status_src: assert property (
        reg_rd && reg_addr == 8'h0c |=>
        reg_rdata[1:0] == $past(active_source) &&
        reg_rdata[3] == $past(pll_locked) &&
        reg_rdata[4] == $past(sys_clk_out))
        else $error("status read disagrees with outputs");
    chk_rise_single: assert property (
        sys_clk_rise |-> sys_clk_out && !$past(sys_clk_out))
        else $error("rise pulse without a rising clock");
    chk_rise_marks: assert property (
        $rose(sys_clk_out) |-> sys_clk_rise)
        else $error("clock rise without its pulse");
    chk_undef_hold: assert property (
        sel_wr && reg_wdata[1:0] == 2'h1 |=> $stable(active_source)[*8])
        else $error("undefined select moved the source");
    chk_direct_reach: assert property (
        sel_wr && reg_wdata[1:0] == 2'h3 |-> ##[1:200] active_source == 2'h3)
        else $error("direct drive not reached");
    chk_wake_reach: assert property (
        sel_wr && reg_wdata[1:0] == 2'h0 |-> ##[1:300] active_source == 2'h0)
        else $error("wakeup source not reached");
    chk_switch_low: assert property (
        $changed(active_source) |-> !sys_clk_out)
        else $error("source changed while clock high");
    // bench drives the direct pin high 3 cycles, low 3 cycles
    chk_direct_duty: assert property (
        $rose(sys_clk_out) && active_source == 2'h3 |->
        sys_clk_out[*3] ##1 !sys_clk_out)
        else $error("direct clock high phase differs from input");
endmodule : scss_top_chk

bind scss_top scss_top_chk u_chk (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .sys_clk_out   (sys_clk_out),
    .sys_clk_rise  (sys_clk_rise),
    .active_source (active_source),
    .pll_locked    (pll_locked)
);

// file: dv/system_clock_source_selector_bench.sv
`timescale 1ns/100ps
module system_clock_source_selector_bench
    import scss_pkg::*;
;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ext_pin = 1'b0;
    logic        xtal_pin = 1'b0;
    logic        int_pin = 1'b0;
    logic        wake_pin = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        sys_clk_out;
    logic        sys_clk_rise;
    logic [1:0]  active_source;
    logic        pll_locked;
    int unsigned cyc = 0;
    int          num_errors = 0;
    int          checks = 0;
    int          p;
    int          s;
    int          k1_q[$];
    logic [31:0] v;
    logic [31:0] w;

    scss_top uut (
        .mclk                 (mclk),
        .sys_rst              (sys_rst),
        .external_clock_input (ext_pin),
        .crystal_input_pin    (xtal_pin),
        .internal_osc_clk     (int_pin),
        .wakeup_osc_clk       (wake_pin),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .sys_clk_out          (sys_clk_out),
        .sys_clk_rise         (sys_clk_rise),
        .active_source        (active_source),
        .pll_locked           (pll_locked)
    );

    always #4 mclk = ~mclk;

    // source periods 6, 8, 10 and 40 mclk, slow enough for the synchronisers
    always @(posedge mclk) begin
        cyc      <= cyc + 1;
        ext_pin  <= (cyc % 6) < 3;
        xtal_pin <= (cyc % 8) < 4;
        int_pin  <= (cyc % 10) < 5;
        wake_pin <= (cyc % 40) < 20;
    end

    function automatic int exp_per(int sel, int refsel, int k1);
        if (sel == 3) return 6;
        if (sel == 0) return 40;
        return (k1 + 1) * (refsel ? 10 : 8);
    endfunction : exp_per

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd

    task automatic chk(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // cycles between two rise pulses, bounded against a dead clock
    task automatic period(output int n);
        int t;
        t = 0;
        n = 1;
        while (sys_clk_rise !== 1'b1 && t < 20000) begin
            @(negedge mclk);
            t++;
        end
        @(negedge mclk);
        while (sys_clk_rise !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
    endtask : period

    // lock must hold 64 cycles in a row, a single match is not enough
    task automatic wait_lock();
        int n;
        int run;
        n = 0;
        run = 0;
        while (run < 64 && n < 30000) begin
            @(negedge mclk);
            n++;
            run = (pll_locked === 1'b1) ? run + 1 : 0;
        end
    endtask : wait_lock

    task automatic final_report();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    initial begin
        #(8 * 100000);
        num_errors++;
        final_report();
    end

    initial begin
        void'($urandom(32'hab7d));
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(8'h00, v);
        chk("cfg_reset", v, 32'h0);
        rd(8'h04, v);
        chk("pll_cfg_reset", v, 32'h1);
        wr(8'h10, 32'h3);
        rd(8'h10, v);
        chk("unmapped", v, 32'h0);
        rd(8'h00, v);
        chk("cfg_kept", v, 32'h0);
        w = $urandom;
        wr(8'h08, w);
        rd(8'h08, v);
        chk("pll_div", v, w & 32'h007f7f0f);
        period(p);
        period(p);
        chk("wake_per", p, exp_per(0, 0, 0));
        $display("test reset_and_wakeup finished");
        wr(8'h00, 32'h3);
        period(p);
        period(p);
        chk("direct_per", p, exp_per(3, 0, 0));
        wr(8'h00, 32'h1);
        period(p);
        chk("undef_per", p, exp_per(3, 0, 0));
        rd(8'h0c, v);
        chk("undef_src", v & 32'h3, 32'h3);
        $display("test direct_and_undefined finished");
        // largest field last, both references covered
        k1_q = '{0, $urandom_range(1, 6), 2048, 2048 + $urandom_range(1, 6),
                 1023};
        foreach (k1_q[i]) begin
            // divider and reference set before the select
            wr(8'h04, 32'h1 | ((k1_q[i] >> 11) << 3)
                      | ((k1_q[i] & 1023) << 16));
            wr(8'h00, 32'h2);
            period(p);
            period(p);
            s = exp_per(2, k1_q[i] >> 11, k1_q[i] & 1023);
            chk("pre_per", p, s);
        end
        rd(8'h0c, v);
        chk("pre_src", v & 32'h3, 32'h2);
        $display("test prescaler finished");
        // rate raised in one modest step between the two bands
        for (int i = 0; i < 2; i++) begin
            wr(8'h08, i ? 32'h00010700 : 32'h00010300);
            wr(8'h04, i ? 32'h0000000a : 32'h0);
            wait_lock();
            s = 0;
            for (int j = 0; j < 8; j++) begin
                period(p);
                s += p;
            end
            chk("pll_lock", pll_locked, 1'b1);
            p = (s >= (i ? 19 : 30)) && (s <= (i ? 21 : 34));
            chk("pll_sum", p, 1'b1);
            rd(8'h0c, v);
            chk("pll_src", v & 32'h3, 32'h1);
        end
        $display("test pll_bands finished");
        wr(8'h00, 32'h0);
        period(p);
        period(p);
        chk("wake_again", p, exp_per(0, 0, 0));
        $display("test back_to_wakeup finished");
        final_report();
    end
endmodule : system_clock_source_selector_bench

// file: src/scss_dpll.sv
`timescale 1ns/100ps
`include "scss_params.svh"
module scss_dpll
    import scss_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      sys_rst,
    input  wire logic      enable,
    input  wire logic      ref_rise,
    input  wire scss_cfg_s cfg,
    output logic           sys_lvl,
    output logic           locked
);
    scss_dpll_st_s st_q;
    scss_dpll_st_s st_d;
    logic [16:0]   sum;
    logic [10:0]   k2_hi;

    always_comb begin
        st_d  = st_q;
        sum   = {1'b0, st_q.acc} + {1'b0, st_q.inc};
        k2_hi = scss_high_len({3'h0, cfg.pll_output_divide_field});
        if (!enable) begin
            st_d.acc     = '0;
            st_d.pcnt    = '0;
            st_d.vcnt    = '0;
            st_d.k2cnt   = '0;
            st_d.sys_lvl = 1'b0;
            st_d.locked  = 1'b0;
        end else begin
            st_d.acc = sum[15:0];
            if (sum[16]) begin
                if (st_q.vcnt != 8'hff) st_d.vcnt = st_q.vcnt + 8'h01;
                st_d.k2cnt = (st_q.k2cnt == cfg.pll_output_divide_field) ? 7'h00
                                                       : st_q.k2cnt + 7'h01;
                st_d.sys_lvl = (cfg.pll_output_divide_field == 7'h00) ? 1'b1
                             : ({4'h0, st_d.k2cnt} < k2_hi);
            end else if (cfg.pll_output_divide_field == 7'h00) begin
                st_d.sys_lvl = 1'b0;
            end
            if (ref_rise) begin
                if (st_q.pcnt == cfg.pll_input_divide_field) begin
                    st_d.pcnt = '0;
                    st_d.vcnt = {7'h00, sum[16]};
                    if (st_q.vcnt < {1'b0, cfg.pll_feedback_multiply_field} + 8'h01) begin
                        st_d.inc = st_q.inc + `SCSS_DPLL_STEP;
                    end else if (st_q.vcnt > {1'b0, cfg.pll_feedback_multiply_field} + 8'h01) begin
                        st_d.inc = st_q.inc - `SCSS_DPLL_STEP;
                    end
                    st_d.locked = (st_q.vcnt == {1'b0, cfg.pll_feedback_multiply_field} + 8'h01);
                end else begin
                    st_d.pcnt = st_q.pcnt + 4'h1;
                end
            end
        end
        if (st_d.inc < scss_band_min(cfg.band) || st_d.inc > st_q.inc
            && st_q.inc > 16'hff00) begin
            st_d.inc = scss_band_min(cfg.band);
        end
        if (st_d.inc > scss_band_max(cfg.band)) begin
            st_d.inc = scss_band_max(cfg.band);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sys_lvl = st_q.sys_lvl;
    assign locked  = st_q.locked;
endmodule : scss_dpll

// file: src/scss_pin_sync.sv
`timescale 1ns/100ps
module scss_pin_sync
    import scss_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] pin_in,
    output logic      [3:0] lvl,
    output logic      [3:0] rise
);
    scss_sync_st_s st_q;
    scss_sync_st_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < 4; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lvl[i] = st_q.s3[i];
            end
        end
        st_d.rise = st_d.lvl & ~st_q.lvl;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign lvl  = st_q.lvl;
    assign rise = st_q.rise;
endmodule : scss_pin_sync

// file: src/scss_top.sv
`timescale 1ns/100ps
`include "scss_params.svh"
module scss_top
    import scss_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        external_clock_input,
    input  wire logic        crystal_input_pin,
    input  wire logic        internal_osc_clk,
    input  wire logic        wakeup_osc_clk,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             sys_clk_out,
    output logic             sys_clk_rise,
    output logic      [1:0]  active_source,
    output logic             pll_locked
);
    localparam scss_top_st_s RST_ST = '{
        cfg: '{sel: `SCSS_RST_SEL, bypass: `SCSS_RST_BYP, default: '0},
        cur: SRC_WAKE,
        sw: SW_RUN,
        default: '0
    };

    scss_top_st_s st_q;
    scss_top_st_s st_d;
    logic [3:0]   pin_lvl;
    logic [3:0]   pin_rise;
    logic         dpll_lvl;
    logic         dpll_lock;
    logic         ref_lvl;
    logic         ref_rise;
    logic         pll_en;
    scss_src_e    want;
    logic [9:0]   k1_next;
    logic [10:0]  k1_hi;

    // pin index order inside the synchroniser
    localparam int PIN_EXT  = 0;
    localparam int PIN_XTAL = 1;
    localparam int PIN_INT  = 2;
    localparam int PIN_WAKE = 3;

    // map a select code to a source; the undefined code keeps the old one
    function automatic scss_src_e want_src(input scss_cfg_s c,
                                           input scss_src_e old);
        scss_src_e r;
        r = old;
        if (c.sel == `SCSS_SEL_DIRECT) begin
            r = SRC_DIRECT;
        end else if (c.sel == `SCSS_SEL_PLLPRE) begin
            r = c.bypass ? SRC_PRE : SRC_PLL;
        end else if (c.sel == `SCSS_SEL_WAKEUP) begin
            r = SRC_WAKE;
        end
        return r;
    endfunction : want_src

    // level that a given source presents to the output mux
    function automatic logic src_level(input scss_src_e s,
                                       input logic [3:0] lvl,
                                       input logic pre,
                                       input logic pll);
        logic r;
        case (s)
            SRC_DIRECT: r = lvl[PIN_EXT];
            SRC_PRE:    r = pre;
            SRC_PLL:    r = pll;
            default:    r = lvl[PIN_WAKE];
        endcase
        return r;
    endfunction : src_level

    scss_pin_sync u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .pin_in  ({wakeup_osc_clk, internal_osc_clk,
                   crystal_input_pin, external_clock_input}),
        .lvl     (pin_lvl),
        .rise    (pin_rise)
    );

    assign ref_lvl  = st_q.cfg.refsel ? pin_lvl[PIN_INT] : pin_lvl[PIN_XTAL];
    assign ref_rise = st_q.cfg.refsel ? pin_rise[PIN_INT]
                                      : pin_rise[PIN_XTAL];

    assign pll_en = (st_q.cfg.sel == `SCSS_SEL_PLLPRE) && !st_q.cfg.bypass;

    scss_dpll u_dpll (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .enable   (pll_en),
        .ref_rise (ref_rise),
        .cfg      (st_q.cfg),
        .sys_lvl  (dpll_lvl),
        .locked   (dpll_lock)
    );

    always_comb begin
        st_d    = st_q;
        want    = want_src(st_q.cfg, st_q.cur);
        k1_hi   = scss_high_len(st_q.cfg.prescaler_divide_field);
        k1_next = st_q.k1cnt;

        // register writes
        if (reg_wr) begin
            if (reg_addr == `SCSS_OFS_SYSCFG) begin
                st_d.cfg.sel = reg_wdata[`SCSS_SEL_LSB +: 2];
            end else if (reg_addr == `SCSS_OFS_PLLCFG) begin
                st_d.cfg.bypass = reg_wdata[`SCSS_BYP_BIT];
                st_d.cfg.band   = reg_wdata[`SCSS_BAND_LSB +: 2];
                st_d.cfg.refsel = reg_wdata[`SCSS_REFSEL_BIT];
                st_d.cfg.prescaler_divide_field  = reg_wdata[`SCSS_K1_LSB +: 10];
            end else if (reg_addr == `SCSS_OFS_PLLDIV) begin
                st_d.cfg.pll_input_divide_field  = reg_wdata[`SCSS_P_LSB +: 4];
                st_d.cfg.pll_feedback_multiply_field  = reg_wdata[`SCSS_N_LSB +: 7];
                st_d.cfg.pll_output_divide_field = reg_wdata[`SCSS_K2_LSB +: 7];
            end
        end

        // register reads: data only in the cycle after the strobe
        st_d.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == `SCSS_OFS_SYSCFG) begin
                st_d.rdata[`SCSS_SEL_LSB +: 2] = st_q.cfg.sel;
            end else if (reg_addr == `SCSS_OFS_PLLCFG) begin
                st_d.rdata[`SCSS_BYP_BIT]        = st_q.cfg.bypass;
                st_d.rdata[`SCSS_BAND_LSB +: 2]  = st_q.cfg.band;
                st_d.rdata[`SCSS_REFSEL_BIT]     = st_q.cfg.refsel;
                st_d.rdata[`SCSS_K1_LSB +: 10]   = st_q.cfg.prescaler_divide_field;
            end else if (reg_addr == `SCSS_OFS_PLLDIV) begin
                st_d.rdata[`SCSS_P_LSB +: 4]  = st_q.cfg.pll_input_divide_field;
                st_d.rdata[`SCSS_N_LSB +: 7]  = st_q.cfg.pll_feedback_multiply_field;
                st_d.rdata[`SCSS_K2_LSB +: 7] = st_q.cfg.pll_output_divide_field;
            end else if (reg_addr == `SCSS_OFS_STATUS) begin
                st_d.rdata[`SCSS_ST_SRC_LSB +: 2] = st_q.cur;
                st_d.rdata[`SCSS_ST_PARK_BIT]     = (st_q.sw == SW_PARK);
                st_d.rdata[`SCSS_ST_LOCK_BIT]     = st_q.locked;
                st_d.rdata[`SCSS_ST_CLK_BIT]      = st_q.sys_clk;
            end
        end

        if (st_q.cfg.prescaler_divide_field == 10'h000) begin
            st_d.k1cnt   = '0;
            st_d.pre_lvl = ref_lvl;
        end else if (ref_rise) begin
            k1_next = (st_q.k1cnt >= st_q.cfg.prescaler_divide_field) ? 10'h000
                                                     : st_q.k1cnt + 10'h001;
            st_d.k1cnt   = k1_next;
            st_d.pre_lvl = ({1'b0, k1_next} < k1_hi);
        end

        st_d.locked = dpll_lock;

        // switch only across a low phase
        case (st_q.sw)
            SW_RUN: begin
                st_d.sys_clk = src_level(st_q.cur, pin_lvl,
                                         st_q.pre_lvl, dpll_lvl);
                if (want != st_q.cur && !st_d.sys_clk) begin
                    st_d.cur = want;
                    st_d.sw  = SW_PARK;
                end
            end
            SW_PARK: begin
                // new source joins at its own low phase, never mid-high
                st_d.sys_clk = 1'b0;
                if (want != st_q.cur) begin
                    st_d.cur = want;
                end else if (!src_level(st_q.cur, pin_lvl,
                                        st_q.pre_lvl, dpll_lvl)) begin
                    st_d.sw = SW_RUN;
                end
            end
            default: begin
                st_d.sw = SW_RUN;
            end
        endcase
        st_d.sys_rise = st_d.sys_clk && !st_q.sys_clk;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= RST_ST;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata     = st_q.rdata;
    assign sys_clk_out   = st_q.sys_clk;
    assign sys_clk_rise  = st_q.sys_rise;
    assign active_source = st_q.cur;
    assign pll_locked    = st_q.locked;
endmodule : scss_top
